/* File: hw/acrr_consts.vh */
// Constants for the converter result readout and interrupt block
`ifndef ACRR_CONSTS_VH
`define ACRR_CONSTS_VH

// Register addresses
`define ACRR_ADDR_W          32
`define ACRR_RES_HIGH_ADDR   32'h04000080
`define ACRR_RES_LOW_ADDR    32'h04000082
`define ACRR_CTRL_ADDR       32'h04000088

// Result and byte layout
`define ACRR_RES_W           10
`define ACRR_BYTE_W          8
`define ACRR_LOW_PAD         6'h00
`define ACRR_ZERO_BYTE       8'h00

// Access sizes
`define ACRR_SIZE_BYTE       2'h0
`define ACRR_SIZE_WORD       2'h1
`define ACRR_SIZE_LONG       2'h2

// Control/status bit positions
`define ACRR_CSR_DONE_BIT    7
`define ACRR_CSR_IEN_BIT     6

`endif

/* File: hw/acrr_lane_fill.v */
// Lane replication of a byte pair onto the 32-bit read data
`include "acrr_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module acrr_lane_fill
(
  input  wire [1:0]  accSize,
  input  wire [7:0]  selByte,
  input  wire [7:0]  highByte,
  input  wire [7:0]  lowByte,
  input  wire        isHighAddr,
  output reg  [31:0] laneData
);

  //----------------------------------------
  // Lane mapping
  //----------------------------------------
  always @*
  begin
    case (accSize)
      `ACRR_SIZE_BYTE:
        laneData = {4{selByte}};
      `ACRR_SIZE_WORD:
        laneData = {selByte, `ACRR_ZERO_BYTE,
                    selByte, `ACRR_ZERO_BYTE};
      `ACRR_SIZE_LONG:
        laneData = isHighAddr ?
                   {highByte, `ACRR_ZERO_BYTE,
                    lowByte, `ACRR_ZERO_BYTE} :
                   {selByte, `ACRR_ZERO_BYTE,
                    selByte, `ACRR_ZERO_BYTE};
      default:
        laneData = {4{selByte}};
    endcase
  end

endmodule
`default_nettype wire

/* File: hw/acrr_readout.v */
// Converter result readout registers and conversion-end interrupt
//
// Function
// - Raise the conversion-end interrupt request when a conversion finishes.
// - Pass the request only while the interrupt enable bit is set.
// - Each result is an unsigned ten-bit code, zero to all ones.
// - Input at the analog reference gives full scale, all ten bits set.
// - High byte holds bits 9..2; low byte holds bits 1..0 at top.
// - High byte at the even base address, low byte two bytes above.
// - Byte read drives the addressed byte on every byte lane.
// - Word read puts the byte in bits 15..8 of each halfword.
// - Long read at high address: high in 31..24, low in 15..8.
// - Conversion end sets the done flag; request is done and enable.
`include "acrr_consts.vh"
`timescale 1ns/10ps
`default_nettype none

module acrr_readout
#(
  parameter RES_W = `ACRR_RES_W
)
(
  input  wire                core_clk,
  input  wire                nrst,
  input  wire                convDone,
  input  wire [RES_W-1:0]    convResult,
  input  wire                busSel,
  input  wire                busWrite,
  input  wire [1:0]          busSize,
  input  wire [31:0]         busAddr,
  input  wire [7:0]          busWrData,
  output reg  [31:0]         busRdData_ff,
  output reg                 busAck_ff,
  output reg                 conversionEndIrq_ff
);

  //----------------------------------------
  // State
  //----------------------------------------
  reg  [RES_W-1:0] result_ff;
  reg              doneFlag_ff;
  reg              irqEnable_ff;
  reg              doneSeen_ff;
  reg              nxt_doneFlag;
  reg              nxt_doneSeen;
  reg  [31:0]      nxt_rdData;
  wire [7:0]       highByte;
  wire [7:0]       lowByte;
  wire [7:0]       ctrlByte;
  wire [31:0]      laneData;
  wire             hitHigh;
  wire             hitLow;
  wire             hitCtrl;
  wire             ctrlWrite;
  wire             ctrlRead;
  reg  [RES_W-1:0] nxt_result;
  reg              nxt_irqEnable;
  reg              nxt_irq;
  reg  [7:0]       selByte;
  wire             rdAccess;
  wire             seenReq;
  wire             clearReq;

  //----------------------------------------
  // Result byte split
  //----------------------------------------
  assign highByte = result_ff[RES_W-1:RES_W-8];
  assign lowByte  = {result_ff[1:0], `ACRR_LOW_PAD};
  assign ctrlByte = {doneFlag_ff, irqEnable_ff, 6'h00};

  //----------------------------------------
  // Address decode
  //----------------------------------------
  assign hitHigh   = busSel && (busAddr == `ACRR_RES_HIGH_ADDR);
  assign hitLow    = busSel && (busAddr == `ACRR_RES_LOW_ADDR);
  assign hitCtrl   = busSel && (busAddr == `ACRR_CTRL_ADDR);
  assign ctrlWrite = hitCtrl && busWrite;
  assign ctrlRead  = hitCtrl && !busWrite;
  assign rdAccess  = busSel && !busWrite;

  //----------------------------------------
  // Clear handshake qualifiers
  //----------------------------------------
  assign seenReq  = ctrlRead && doneFlag_ff;
  assign clearReq = ctrlWrite && !busWrData[`ACRR_CSR_DONE_BIT] &&
                    doneSeen_ff;

  //----------------------------------------
  // Addressed byte select
  //----------------------------------------
  always @*
  begin
    if (hitHigh)
      selByte = highByte;
    else if (hitLow)
      selByte = lowByte;
    else
      selByte = ctrlByte;
  end

  //----------------------------------------
  // Read lane fill
  //----------------------------------------
  acrr_lane_fill u_laneFill
  (
    .accSize    (busSize),
    .selByte    (selByte),
    .highByte   (highByte),
    .lowByte    (lowByte),
    .isHighAddr (hitHigh),
    .laneData   (laneData)
  );

  //----------------------------------------
  // Done flag: set wins over clear
  //----------------------------------------
  always @*
  begin
    nxt_doneFlag = doneFlag_ff;
    nxt_doneSeen = doneSeen_ff;
    if (seenReq)
      nxt_doneSeen = 1'b1;
    if (clearReq)
    begin
      nxt_doneFlag = 1'b0;
      nxt_doneSeen = 1'b0;
    end
    if (convDone)
      nxt_doneFlag = 1'b1;
  end

  //----------------------------------------
  // Read data mux
  //----------------------------------------
  always @*
  begin
    if (rdAccess && (hitHigh || hitLow || hitCtrl))
      nxt_rdData = laneData;
    else
      nxt_rdData = 32'h00000000;
  end

  //----------------------------------------
  // Result capture
  //----------------------------------------
  always @*
  begin
    nxt_result = result_ff;
    if (convDone)
      nxt_result = convResult;
  end

  //----------------------------------------
  // Interrupt enable and request
  //----------------------------------------
  always @*
  begin
    nxt_irqEnable = irqEnable_ff;
    if (ctrlWrite)
      nxt_irqEnable = busWrData[`ACRR_CSR_IEN_BIT];
    nxt_irq = nxt_doneFlag && nxt_irqEnable;
  end

  //----------------------------------------
  // Result register
  //----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
      result_ff <= {RES_W{1'b0}};
    else
      result_ff <= nxt_result;
  end

  //----------------------------------------
  // Done flag and read-seen marker
  //----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      doneFlag_ff <= 1'b0;
      doneSeen_ff <= 1'b0;
    end
    else
    begin
      doneFlag_ff <= nxt_doneFlag;
      doneSeen_ff <= nxt_doneSeen;
    end
  end

  //----------------------------------------
  // Interrupt enable and request registers
  //----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irqEnable_ff        <= 1'b0;
      conversionEndIrq_ff <= 1'b0;
    end
    else
    begin
      irqEnable_ff        <= nxt_irqEnable;
      conversionEndIrq_ff <= nxt_irq;
    end
  end

  //----------------------------------------
  // Bus response registers
  //----------------------------------------
  always @(posedge core_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busRdData_ff <= 32'h00000000;
      busAck_ff    <= 1'b0;
    end
    else
    begin
      busRdData_ff <= nxt_rdData;
      busAck_ff    <= busSel;
    end
  end

endmodule
`default_nettype wire

/* File: sim/acrr_cpu_model.sv */
// Processor bus master model
`timescale 1ns/10ps
`default_nettype none
module acrr_cpu_model
(
  input wire logic core_clk,
  input wire logic [31:0] rdData,
  output logic busSel,
  output logic busWrite,
  output logic [1:0] busSize,
  output logic [31:0] busAddr,
  output logic [7:0] busWrData
);
  initial {busSel, busWrite, busSize, busAddr, busWrData} = '0;
  task automatic xfer(input [1:0] s, input [31:0] a, input [7:0] d,
    input w, output [31:0] q);
    @(posedge core_clk) #1;
    {busSel, busWrite, busSize, busAddr, busWrData} = {1'h1, w, s, a, d};
    @(posedge core_clk) #1;
    q = rdData;
    busSel = 1'h0;
    busAddr = ~a;
    busWrData = ~d;
  endtask
  // Read the flag set, then write zero to it
  task automatic svc(output [31:0] q);
    logic [31:0] t;
    xfer(2'h0, 32'h04000088, 8'h00, 1'h0, q);
    xfer(2'h0, 32'h04000088, {1'h0, q[6], 6'h00}, 1'h1, t);
  endtask
endmodule
`default_nettype wire

/* File: sim/acrr_readout_bench.sv */
// Self-checking bench for the readout block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,e) begin numChecks++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t %h %h", $time, (a), (e)); end end
module acrr_readout_bench;
  logic core_clk = 0, nrst = 0, convDone = 0;
  logic busSel, busWrite, busAck_ff, conversionEndIrq_ff;
  logic [9:0] convResult = 0;
  logic [1:0] busSize;
  logic [31:0] busAddr, busRdData_ff, q;
  logic [7:0] busWrData;
  int failures = 0, numChecks = 0;
  logic [65:0] rows [6] = '{{2'h0, 32'h04000080, 32'hadadadad},
    {2'h0, 32'h04000082, 32'h40404040}, {2'h1, 32'h04000080, 32'had00ad00},
    {2'h1, 32'h04000082, 32'h40004000}, {2'h2, 32'h04000080, 32'had004000},
    {2'h0, 32'h04000084, 32'h00000000}};
  acrr_readout dut(.*);
  acrr_cpu_model cpu(.*, .rdData(busRdData_ff));
  initial forever #4 core_clk = ~core_clk;
  task conv(input [9:0] r);
    @(posedge core_clk) #1;
    convDone = 1'h1;
    convResult = r;
    @(posedge core_clk) #1;
    convDone = 1'h0;
    convResult = ~r;
  endtask
  task endSim;
    $display("checks %0d failures %0d", numChecks, failures);
    if (failures == 0 && numChecks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge core_clk);
    #1;
    `CHK({busAck_ff, conversionEndIrq_ff, busRdData_ff}, 34'h0)
    nrst = 1'h1;
    conv(10'h2b5);
    `CHK(conversionEndIrq_ff, 1'h0)
    cpu.xfer(2'h0, 32'h04000080, 8'h00, 1'h1, q);
    foreach (rows[i])
    begin
      cpu.xfer(rows[i][65:64], rows[i][63:32], 8'h00, 1'h0, q);
      `CHK(q, rows[i][31:0])
      `CHK(busAck_ff, 1'h1)
    end
    cpu.xfer(2'h0, 32'h04000088, 8'h40, 1'h1, q);
    repeat (5) @(posedge core_clk);
    `CHK(conversionEndIrq_ff, 1'h1)
    cpu.svc(q);
    `CHK(q, 32'hc0c0c0c0)
    `CHK(conversionEndIrq_ff, 1'h0)
    cpu.xfer(2'h0, 32'h04000088, 8'h00, 1'h1, q);
    conv(10'h3ff);
    `CHK(conversionEndIrq_ff, 1'h0)
    cpu.xfer(2'h2, 32'h04000080, 8'h00, 1'h0, q);
    `CHK(q, 32'hff00c000)
    cpu.xfer(2'h0, 32'h04000088, 8'h40, 1'h1, q);
    `CHK(conversionEndIrq_ff, 1'h1)
    // Clear without a prior read of the flag is ignored
    cpu.xfer(2'h0, 32'h04000088, 8'h40, 1'h1, q);
    `CHK(conversionEndIrq_ff, 1'h1)
    cpu.xfer(2'h0, 32'h04000088, 8'h00, 1'h0, q);
    `CHK(q, 32'hc0c0c0c0)
    // New result in the cycle of the clear: the set wins
    fork
      conv(10'h155);
      cpu.xfer(2'h0, 32'h04000088, 8'h40, 1'h1, q);
    join
    `CHK(conversionEndIrq_ff, 1'h1)
    cpu.xfer(2'h2, 32'h04000080, 8'h00, 1'h0, q);
    `CHK(q, 32'h55004000)
    cpu.xfer(2'h0, 32'h04000088, 8'h00, 1'h1, q);
    `CHK(conversionEndIrq_ff, 1'h0)
    cpu.xfer(2'h0, 32'h04000088, 8'h40, 1'h1, q);
    `CHK(conversionEndIrq_ff, 1'h1)
    // Reset in mid-run
    nrst = 1'h0;
    @(posedge core_clk) #1;
    `CHK({busAck_ff, conversionEndIrq_ff, busRdData_ff}, 34'h0)
    nrst = 1'h1;
    cpu.xfer(2'h0, 32'h04000088, 8'h00, 1'h0, q);
    `CHK(q, 32'h00000000)
    cpu.xfer(2'h1, 32'h04000080, 8'h00, 1'h0, q);
    `CHK(q, 32'h00000000)
    endSim;
  end
endmodule
`default_nettype wire

/* File: sim/acrr_readout_sva.sv */
// Checker for the readout block
`timescale 1ns/10ps
`default_nettype none
module acrr_readout_sva
#(parameter RES_W = 10)
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic convDone,
  input wire logic [RES_W-1:0] convResult,
  input wire logic busSel,
  input wire logic busWrite,
  input wire logic [1:0] busSize,
  input wire logic [31:0] busAddr,
  input wire logic [7:0] busWrData,
  input wire logic [31:0] busRdData_ff,
  input wire logic busAck_ff,
  input wire logic conversionEndIrq_ff
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  wire rd = busSel && !busWrite;
  wire wr = busSel && busWrite;
  sequence byteRd;
    rd && busSize == 2'h0;
  endsequence
  ack_next_a: assert property (busSel |=> busAck_ff)
    else $error("missing ack");
  ack_only_a: assert property (!busSel |=> !busAck_ff)
    else $error("stray ack");
  byte_lanes_a: assert property (byteRd |=>
    busRdData_ff[31:8] == {3{busRdData_ff[7:0]}}) else $error("lanes");
  low_pad_a: assert property ((byteRd and busAddr == 32'h04000082) |=>
    busRdData_ff[5:0] == 6'h00) else $error("low pad");
  word_lanes_a: assert property (rd && busSize == 2'h1 |=>
    busRdData_ff[31:24] == busRdData_ff[15:8]) else $error("word lanes");
  long_low_a: assert property (rd && busSize == 2'h2 &&
    busAddr == 32'h04000080 |=> busRdData_ff[13:8] == 6'h00)
    else $error("long low byte");
  irq_hold_a: assert property (conversionEndIrq_ff && !wr |=>
    conversionEndIrq_ff) else $error("irq dropped");
  irq_cause_a: assert property ($rose(conversionEndIrq_ff) |->
    $past(convDone) || $past(wr)) else $error("irq without cause");
  irq_mask_a: assert property (wr && busAddr == 32'h04000088 &&
    !busWrData[6] |=> !conversionEndIrq_ff) else $error("irq not masked");
endmodule
bind acrr_readout acrr_readout_sva #(.RES_W(RES_W)) chk(.*);
`default_nettype wire
